// >>> hdl/gpib_status_defines.svh
// constants for the status reporting and service request block
`ifndef GPIB_STATUS_DEFINES_SVH
`define GPIB_STATUS_DEFINES_SVH

`define STB_RQS_BIT          6
`define STB_ESB_BIT          5
`define STB_USED_MASK        8'h60
`define SRE_USED_MASK        8'h20
`define ESR_CMD_ERR_BIT      5
`define ESR_EXEC_ERR_BIT     4
`define ESR_BAD_INPUT_BIT    1
`define ESR_WITHIN_RANGE_BIT 0
`define ESR_USED_MASK        8'h33
`define RANGE_LIMIT          20
`define BYTE_RESET           8'h00

`endif

// >>> hdl/gpib_status_pkg.sv
// types shared by the status reporting block
package gpib_status_pkg;

    // decoded interface messages from the bus front end, one-cycle pulses
    typedef struct packed {
        logic my_talk;
        logic my_listen;
        logic untalk;
        logic unlisten;
        logic spoll_enable;
        logic spoll_disable;
        logic ifc;
    } bus_cmd_s;

    // strobes from the message parser and handshake, one-cycle pulses
    typedef struct packed {
        logic spoll_done;
        logic stb_query;
        logic esr_query;
        logic clear_status;
        logic sre_write;
        logic ese_write;
    } status_req_s;

    // device conditions, levels or pulses
    typedef struct packed {
        logic cmd_error;
        logic exec_error;
        logic bad_input;
    } dev_event_s;

    typedef enum logic [1:0] {
        TALK_IDLE  = 2'b00,
        TALK_ADDR  = 2'b01,
        TALK_SPOLL = 2'b10
    } talk_state_e;

    typedef enum logic {
        LISTEN_IDLE = 1'b0,
        LISTEN_ADDR = 1'b1
    } listen_state_e;

endpackage : gpib_status_pkg

// >>> hdl/event_status_reg.sv
// standard event status register with its enable mask and summary bit
`include "gpib_status_defines.svh"

module event_status_reg #(
    parameter int VALUE_W = 8
) (
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire gpib_status_pkg::dev_event_s events,
    input  wire logic [VALUE_W-1:0]          measured_value,
    input  wire logic                        clear_status,
    input  wire logic                        esr_read,
    input  wire logic                        ese_write,
    input  wire logic [7:0]                  wr_data,
    output logic      [7:0]                  esr,
    output logic      [7:0]                  ese,
    output logic                             esb
);

    logic       in_range;
    logic       in_range_q;
    logic [7:0] set_bits;

    assign in_range = measured_value <= VALUE_W'(`RANGE_LIMIT);

    always_ff @(posedge clk) begin
        if (rst) in_range_q <= 1'b0;
        else     in_range_q <= in_range;
    end

    always_comb begin
        set_bits = `BYTE_RESET;
        set_bits[`ESR_CMD_ERR_BIT]      = events.cmd_error;
        set_bits[`ESR_EXEC_ERR_BIT]     = events.exec_error;
        set_bits[`ESR_BAD_INPUT_BIT]    = events.bad_input;
        set_bits[`ESR_WITHIN_RANGE_BIT] = in_range && !in_range_q;
    end

    // an event landing on a clear is kept: set wins
    always_ff @(posedge clk) begin
        if (rst)
            esr <= `BYTE_RESET;
        else if (clear_status || esr_read)
            esr <= set_bits;
        else
            esr <= esr | set_bits;
    end

    always_ff @(posedge clk) begin
        if (rst)            ese <= `BYTE_RESET;
        else if (ese_write) ese <= wr_data & `ESR_USED_MASK;
    end

    always_ff @(posedge clk) begin
        if (rst) esb <= 1'b0;
        else     esb <= |(esr & ese);
    end

    ////////////////////////////////////////////////////////////////////////
    property p_cmd_err_set;
        @(posedge clk) disable iff (rst)
        events.cmd_error |=> esr[`ESR_CMD_ERR_BIT];
    endproperty
    a_cmd_err_set: assert property (p_cmd_err_set)
        else $error("command error not flagged");

    property p_bad_input_set;
        @(posedge clk) disable iff (rst)
        events.bad_input |=> esr[`ESR_BAD_INPUT_BIT] ##1
            (esr[`ESR_BAD_INPUT_BIT] || $past(clear_status || esr_read));
    endproperty
    a_bad_input_set: assert property (p_bad_input_set)
        else $error("bad input flag lost");

    property p_range_set;
        @(posedge clk) disable iff (rst)
        (in_range && !in_range_q) |=> esr[`ESR_WITHIN_RANGE_BIT];
    endproperty
    a_range_set: assert property (p_range_set)
        else $error("within range flag not set");

    property p_clear;
        @(posedge clk) disable iff (rst)
        (clear_status && set_bits == `BYTE_RESET) |=> esr == `BYTE_RESET;
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear status left bits set");

    property p_esb_summary;
        @(posedge clk) disable iff (rst)
        ##1 esb == |($past(esr) & $past(ese));
    endproperty
    a_esb_summary: assert property (p_esb_summary)
        else $error("event summary bit wrong");

endmodule : event_status_reg

// >>> hdl/gpib_status_service_request.sv
// status byte, service request and addressed talker/listener state
`include "gpib_status_defines.svh"

module gpib_status_service_request #(
    parameter int VALUE_W = 8
) (
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire gpib_status_pkg::bus_cmd_s    bus,
    input  wire gpib_status_pkg::status_req_s req,
    input  wire logic [7:0]                   wr_data,
    input  wire gpib_status_pkg::dev_event_s  events,
    input  wire logic [VALUE_W-1:0]           measured_value,
    output logic      [7:0]                   resp_data,
    output logic                              resp_valid,
    output logic      [7:0]                   status_summary_byte,
    output logic      [7:0]                   service_request_mask,
    output logic                              srq_out,
    output logic                              srq_drive_n,
    output logic                              talker_active,
    output logic                              listener_active,
    output logic                              spoll_active
);

    gpib_status_pkg::talk_state_e   talk_state;
    gpib_status_pkg::talk_state_e   next_talk_state;
    gpib_status_pkg::listen_state_e listen_state;
    gpib_status_pkg::listen_state_e next_listen_state;

    logic       spoll_mode;
    logic       rqs;
    logic       mss;
    logic       mss_q;
    logic       rqs_set;
    logic       poll_taken;
    logic       esb;
    logic [7:0] esr;
    logic [7:0] ese;
    logic [7:0] summary_bits;
    logic [7:0] sre;

    ////////////////////////////////////////////////////////////////////////
    // event status register and its summary

    event_status_reg #(
        .VALUE_W (VALUE_W)
    ) u_esr (
        .clk            (clk),
        .rst            (rst),
        .events         (events),
        .measured_value (measured_value),
        .clear_status   (req.clear_status),
        .esr_read       (req.esr_query),
        .ese_write      (req.ese_write),
        .wr_data        (wr_data),
        .esr            (esr),
        .ese            (ese),
        .esb            (esb)
    );

    ////////////////////////////////////////////////////////////////////////
    // status byte assembly

    function automatic logic [7:0] status_byte(input logic bit6,
                                               input logic bit5);
        logic [7:0] b;
        b = `BYTE_RESET;
        b[`STB_RQS_BIT] = bit6;
        b[`STB_ESB_BIT] = bit5;
        return b & `STB_USED_MASK;
    endfunction : status_byte

    assign summary_bits = status_byte(1'b0, esb);
    // bit 6 never takes part in its own summary
    assign mss        = |(summary_bits & sre);
    assign rqs_set    = mss && !mss_q;
    assign poll_taken = (talk_state == gpib_status_pkg::TALK_SPOLL) &&
                        req.spoll_done;

    always_ff @(posedge clk) begin
        if (rst) sre <= `BYTE_RESET;
        else if (req.sre_write) sre <= wr_data & `SRE_USED_MASK;
    end

    always_ff @(posedge clk) begin
        if (rst) mss_q <= 1'b0;
        else     mss_q <= mss;
    end

    // a fresh request arriving with the poll wins over the clear
    always_ff @(posedge clk) begin
        if (rst)             rqs <= 1'b0;
        else if (rqs_set)    rqs <= 1'b1;
        else if (poll_taken) rqs <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // service request pin, open collector: pulled low while driving

    always_ff @(posedge clk) begin
        if (rst) srq_out <= 1'b0;
        else     srq_out <= 1'b0;
    end

    always_ff @(posedge clk) begin
        if (rst) srq_drive_n <= 1'b1;
        else     srq_drive_n <= !rqs;
    end

    ////////////////////////////////////////////////////////////////////////
    // serial poll mode, set and cleared by universal messages

    always_ff @(posedge clk) begin
        if (rst || bus.ifc)         spoll_mode <= 1'b0;
        else if (bus.spoll_enable)  spoll_mode <= 1'b1;
        else if (bus.spoll_disable) spoll_mode <= 1'b0;
    end

    // talker: only its own talk address makes it active
    always_comb begin
        next_talk_state = talk_state;
        unique case (talk_state)
            gpib_status_pkg::TALK_IDLE: begin
                if (bus.my_talk)
                    next_talk_state = spoll_mode ?
                        gpib_status_pkg::TALK_SPOLL :
                        gpib_status_pkg::TALK_ADDR;
            end
            gpib_status_pkg::TALK_ADDR: begin
                if (bus.untalk)
                    next_talk_state = gpib_status_pkg::TALK_IDLE;
                else if (bus.spoll_enable)
                    next_talk_state = gpib_status_pkg::TALK_SPOLL;
            end
            gpib_status_pkg::TALK_SPOLL: begin
                if (bus.untalk)
                    next_talk_state = gpib_status_pkg::TALK_IDLE;
                else if (bus.spoll_disable)
                    next_talk_state = gpib_status_pkg::TALK_ADDR;
            end
            default: next_talk_state = gpib_status_pkg::TALK_IDLE;
        endcase
        if (bus.ifc)
            next_talk_state = gpib_status_pkg::TALK_IDLE;
    end

    always_ff @(posedge clk) begin
        if (rst) talk_state <= gpib_status_pkg::TALK_IDLE;
        else     talk_state <= next_talk_state;
    end

    // listener: own listen address only; own talk address unaddresses it
    always_comb begin
        next_listen_state = listen_state;
        unique case (listen_state)
            gpib_status_pkg::LISTEN_IDLE: begin
                if (bus.my_listen)
                    next_listen_state = gpib_status_pkg::LISTEN_ADDR;
            end
            gpib_status_pkg::LISTEN_ADDR: begin
                if (bus.unlisten || bus.my_talk)
                    next_listen_state = gpib_status_pkg::LISTEN_IDLE;
            end
        endcase
        if (bus.ifc)
            next_listen_state = gpib_status_pkg::LISTEN_IDLE;
    end

    always_ff @(posedge clk) begin
        if (rst) listen_state <= gpib_status_pkg::LISTEN_IDLE;
        else     listen_state <= next_listen_state;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            talker_active   <= 1'b0;
            listener_active <= 1'b0;
            spoll_active    <= 1'b0;
        end else begin
            talker_active   <= next_talk_state != gpib_status_pkg::TALK_IDLE;
            listener_active <= next_listen_state ==
                               gpib_status_pkg::LISTEN_ADDR;
            spoll_active    <= next_talk_state == gpib_status_pkg::TALK_SPOLL;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // responses: serial poll byte carries the request, query the summary

    always_ff @(posedge clk) begin
        if (rst)
            status_summary_byte <= `BYTE_RESET;
        else
            status_summary_byte <= status_byte(rqs, esb);
    end

    always_ff @(posedge clk) begin
        if (rst)
            service_request_mask <= `BYTE_RESET;
        else
            service_request_mask <= sre;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            resp_data  <= `BYTE_RESET;
            resp_valid <= 1'b0;
        end else if (req.esr_query) begin
            resp_data  <= esr;
            resp_valid <= 1'b1;
        end else if (req.stb_query) begin
            resp_data  <= status_byte(mss, esb);
            resp_valid <= 1'b1;
        end else if (talk_state == gpib_status_pkg::TALK_SPOLL) begin
            resp_data  <= status_byte(rqs, esb);
            resp_valid <= 1'b0;
        end else begin
            resp_valid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_request;
        rqs_set;
    endsequence

    sequence s_poll_clear;
        poll_taken && !rqs_set;
    endsequence

    property p_rqs_set;
        @(posedge clk) disable iff (rst)
        s_request |=> rqs;
    endproperty
    a_rqs_set: assert property (p_rqs_set)
        else $error("request bit not set on new summary");

    property p_rqs_clear;
        @(posedge clk) disable iff (rst)
        s_poll_clear |=> !rqs;
    endproperty
    a_rqs_clear: assert property (p_rqs_clear)
        else $error("serial poll did not clear request bit");

    property p_query_mss;
        @(posedge clk) disable iff (rst)
        (req.stb_query && !req.esr_query) |=>
            resp_valid && resp_data[`STB_RQS_BIT] == $past(mss) &&
            resp_data[`STB_ESB_BIT] == $past(esb);
    endproperty
    a_query_mss: assert property (p_query_mss)
        else $error("status query byte wrong");

    property p_unused_bits;
        @(posedge clk) disable iff (rst)
        (status_summary_byte & ~`STB_USED_MASK) == `BYTE_RESET &&
        (service_request_mask & ~`STB_USED_MASK) == `BYTE_RESET;
    endproperty
    a_unused_bits: assert property (p_unused_bits)
        else $error("unused status bit set");

    property p_talk_addr;
        @(posedge clk) disable iff (rst)
        $rose(talker_active) |-> $past(bus.my_talk);
    endproperty
    a_talk_addr: assert property (p_talk_addr)
        else $error("talker active without own talk address");

    property p_listen_addr;
        @(posedge clk) disable iff (rst)
        $rose(listener_active) |-> $past(bus.my_listen);
    endproperty
    a_listen_addr: assert property (p_listen_addr)
        else $error("listener active without own listen address");

    property p_srq_assert;
        @(posedge clk) disable iff (rst)
        s_request |-> ##2 !srq_drive_n;
    endproperty
    a_srq_assert: assert property (p_srq_assert)
        else $error("service request line not driven");

    property p_srq_release;
        @(posedge clk) disable iff (rst)
        s_poll_clear ##1 !rqs_set |-> ##1 srq_drive_n;
    endproperty
    a_srq_release: assert property (p_srq_release)
        else $error("service request line not released");

endmodule : gpib_status_service_request

// >>> sim/gpib_controller_model.sv
// bus controller model: addressing, serial poll and poll completion
module gpib_controller_model (
    input  wire logic                 clk,
    output gpib_status_pkg::bus_cmd_s bus,
    output logic                      poll_done
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        bus = '0;
        poll_done = 1'b0;
    end

    // one-cycle message, changed only just after an edge
    task automatic send(input logic [6:0] m);
        @(posedge clk) bus <= m;
        @(posedge clk) bus <= '0;
    endtask : send

    // poll mode first, then address as talker
    task automatic start_poll();
        send(7'h04);
        send(7'h40);
    endtask : start_poll

    // poll byte taken, then poll mode off and untalk
    task automatic finish_poll();
        @(posedge clk) poll_done <= 1'b1;
        @(posedge clk) poll_done <= 1'b0;
        send(7'h02);
        send(7'h10);
    endtask : finish_poll
endmodule : gpib_controller_model

// >>> sim/tb.sv
// self-checking bench for the status byte and service request block
module tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic                           clk;
    logic                           rst;
    gpib_status_pkg::bus_cmd_s      bus;
    gpib_status_pkg::status_req_s   tb_req;
    gpib_status_pkg::status_req_s   req;
    logic                           poll_done;
    logic [7:0]                     wr_data;
    gpib_status_pkg::dev_event_s    events;
    logic [7:0]                     measured_value;
    logic [7:0]                     resp_data;
    logic                           resp_valid;
    logic [7:0]                     status_summary_byte;
    logic [7:0]                     service_request_mask;
    logic                           srq_drive_n;
    logic                           srq_out;
    logic                           talker_active;
    logic                           listener_active;
    logic                           spoll_active;
    int                             err_total;
    int                             total_checks;

    always_comb begin
        req = tb_req;
        req.spoll_done = poll_done;
    end

    gpib_status_service_request #(.VALUE_W(8)) i_gpib_status_service_request (
        .clk(clk), .rst(rst), .bus(bus), .req(req), .wr_data(wr_data),
        .events(events), .measured_value(measured_value),
        .resp_data(resp_data), .resp_valid(resp_valid),
        .status_summary_byte(status_summary_byte),
        .service_request_mask(service_request_mask), .srq_out(srq_out),
        .srq_drive_n(srq_drive_n), .talker_active(talker_active),
        .listener_active(listener_active), .spoll_active(spoll_active)
    );

    gpib_controller_model i_gpib_controller_model (
        .clk(clk), .bus(bus), .poll_done(poll_done)
    );

    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("checks=%0d errors=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic ticks(input int n);
        repeat (n) @(posedge clk);
    endtask : ticks

    // req bits: done, stb, esr, clear, sre, ese
    task automatic strobe(input logic [5:0] r, input logic [7:0] d);
        @(posedge clk) tb_req <= r;
        wr_data <= d;
        @(posedge clk) tb_req <= '0;
    endtask : strobe

    task automatic query(input logic [5:0] r, input logic [7:0] exp);
        strobe(r, 8'h00);
        #1;
        check({7'h00, resp_valid}, 8'h01);
        check(resp_data, exp);
    endtask : query

    task automatic pulse_event(input logic [2:0] e);
        @(posedge clk) events <= e;
        @(posedge clk) events <= '0;
    endtask : pulse_event

    ////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        #1;
        check(status_summary_byte, 8'h00);
        check(service_request_mask, 8'h00);
        check({7'h00, srq_drive_n}, 8'h01);
        check({7'h00, srq_out}, 8'h00);
        check({5'h00, talker_active, listener_active, spoll_active},
              8'h00);
    endtask : t_reset

    task automatic t_masks();
        strobe(6'h02, 8'hff);
        // the visible mask is a registered copy, one cycle behind
        ticks(1);
        #1 check(service_request_mask, 8'h20);
        strobe(6'h02, 8'h00);
        strobe(6'h01, 8'hff);
        query(6'h08, 8'h00);
    endtask : t_masks

    task automatic t_events();
        pulse_event(3'b100);
        query(6'h08, 8'h20);
        query(6'h08, 8'h00);
        pulse_event(3'b010);
        query(6'h08, 8'h10);
        pulse_event(3'b001);
        query(6'h08, 8'h02);
        // 21 is just outside the range, 20 is the boundary inside it
        @(posedge clk) measured_value <= 8'h15;
        ticks(2);
        query(6'h08, 8'h00);
        @(posedge clk) measured_value <= 8'h14;
        ticks(2);
        query(6'h08, 8'h01);
        @(posedge clk) measured_value <= 8'h64;
        pulse_event(3'b100);
        strobe(6'h04, 8'h00);
        query(6'h08, 8'h00);
    endtask : t_events

    task automatic t_summary();
        pulse_event(3'b010);
        ticks(3);
        #1 check(status_summary_byte, 8'h20);
        check({7'h00, srq_drive_n}, 8'h01);
        query(6'h10, 8'h20);
        // both queries at once: the event register answer has priority
        query(6'h18, 8'h10);
    endtask : t_summary

    task automatic t_srq();
        strobe(6'h02, 8'h20);
        pulse_event(3'b100);
        ticks(4);
        #1 check(status_summary_byte, 8'h60);
        check({7'h00, srq_drive_n}, 8'h00);
        query(6'h10, 8'h60);
        // poll completion while not in poll state must not clear
        i_gpib_controller_model.finish_poll();
        ticks(2);
        #1 check(status_summary_byte, 8'h60);
        check({7'h00, srq_drive_n}, 8'h00);
        check({7'h00, srq_out}, 8'h00);
        i_gpib_controller_model.start_poll();
        ticks(3);
        #1 check({6'h00, spoll_active, talker_active}, 8'h03);
        check(resp_data, 8'h60);
        i_gpib_controller_model.finish_poll();
        ticks(1);
        #1 check(status_summary_byte, 8'h20);
        check({7'h00, srq_drive_n}, 8'h01);
        query(6'h08, 8'h20);
    endtask : t_srq

    task automatic t_addr();
        i_gpib_controller_model.send(7'h20);
        #1 check({7'h00, listener_active}, 8'h01);
        i_gpib_controller_model.send(7'h08);
        #1 check({7'h00, listener_active}, 8'h00);
        i_gpib_controller_model.send(7'h40);
        #1 check({6'h00, talker_active, spoll_active}, 8'h02);
        i_gpib_controller_model.send(7'h10);
        #1 check({7'h00, talker_active}, 8'h00);
        i_gpib_controller_model.send(7'h20);
        i_gpib_controller_model.send(7'h01);
        #1 check({7'h00, listener_active}, 8'h00);
        // own talk address unaddresses the listener
        i_gpib_controller_model.send(7'h20);
        i_gpib_controller_model.send(7'h40);
        #1 check({6'h00, talker_active, listener_active}, 8'h02);
        // poll mode entered while already addressed as talker
        i_gpib_controller_model.send(7'h04);
        #1 check({7'h00, spoll_active}, 8'h01);
        i_gpib_controller_model.send(7'h01);
        #1 check({6'h00, talker_active, spoll_active}, 8'h00);
    endtask : t_addr

    // reset in mid-run with a pending request and an addressed listener
    task automatic t_rst_mid();
        strobe(6'h02, 8'h20);
        pulse_event(3'b100);
        i_gpib_controller_model.send(7'h20);
        ticks(1);
        #1 check({7'h00, srq_drive_n}, 8'h00);
        @(posedge clk) rst <= 1'b1;
        ticks(2);
        @(posedge clk) rst <= 1'b0;
        t_reset();
        query(6'h08, 8'h00);
    endtask : t_rst_mid

    ////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // whole run is about 120 cycles; this leaves wide margin
    initial begin
        #100us;
        err_total++;
        complete_run();
    end

    initial begin
        err_total = 0;
        total_checks = 0;
        rst = 1'b1;
        tb_req = '0;
        wr_data = 8'h00;
        events = '0;
        measured_value = 8'h64;
        ticks(4);
        @(posedge clk) rst <= 1'b0;
        t_reset();
        t_masks();
        t_events();
        t_summary();
        t_srq();
        t_rst_mid();
        t_addr();
        complete_run();
    end
endmodule : tb
